//--- src/dpl_top.sv
// dual loop divider, pump and lock block behind the serial config port
`timescale 1ns/100ps
module dpl_top
  import dpl_pkg::*;
#(
  parameter int CAL_TIMEOUT_CYC = CAL_TIMEOUT
) (
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST,
  // serial configuration pins
  input  wire logic       SER_CLK,
  input  wire logic       SER_DATA,
  input  wire logic       SER_LE,
  output logic            SER_DOUT,
  output logic            SER_DOUT_OE,
  // reference and oscillator pins
  input  wire logic [2:0] REF_IN,
  input  wire logic [1:0] ACTIVE_INPUT,
  input  wire logic       L1_FB_IN,
  input  wire logic       OSC_IN,
  input  wire logic       VCO_IN,
  input  wire logic       OSC_INTERNAL_MODE,
  // pump drives
  output dpl_pump_s       LOOP1_PUMP,
  output logic [1:0]      LOOP1_PUMP_CURRENT,
  output dpl_pump_s       LOOP2_PUMP,
  output logic [1:0]      LOOP2_PUMP_CURRENT,
  // status and settings
  output logic            LOOP2_LOCKED,
  output logic            CAL_ACTIVE,
  output logic            SYNC_PULSE,
  output logic            LOOP2_FAST_PD,
  output logic [2:0]      OSC_INPUT_RANGE
);
  localparam int NPIN = 12;
  localparam int TW   = $clog2(CAL_TIMEOUT_CYC + 1);

  logic [NPIN-1:0] pin;     // raw pins
  logic [NPIN-1:0] s1_q;    // first sync stage
  logic [NPIN-1:0] s2_q;    // second sync stage
  logic [NPIN-1:0] s3_q;    // edge history
  logic [NPIN-1:0] rise;    // rising edges
  logic [NPIN-1:0] fall;    // falling edges

  assign pin = {SER_CLK, SER_DATA, SER_LE, REF_IN, ACTIVE_INPUT,
                L1_FB_IN, OSC_IN, VCO_IN, OSC_INTERNAL_MODE};

  // two flops on every pin, a third only for edges
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

  // named views of the synchronised pins
  logic       sclk_r;   // serial clock rising
  logic       sclk_f;   // serial clock falling
  logic       sdat;     // serial data level
  logic       le;       // latch enable level
  logic       le_r;     // latch enable rising
  logic [2:0] ref_r;    // reference input edges
  logic [1:0] act;      // active input select
  logic       l1fb_r;   // loop1 feedback edge
  logic       osc_r;    // oscillator rising
  logic       osc_f;    // oscillator falling
  logic       vco_r;    // vco edge
  logic       int_mode; // internal oscillator mode

  assign sclk_r   = rise[11];
  assign sclk_f   = fall[11];
  assign sdat     = s2_q[10];
  assign le       = s2_q[9];
  assign le_r     = rise[9];
  assign ref_r    = rise[8:6];
  assign act      = s2_q[5:4];
  assign l1fb_r   = rise[3];
  assign osc_r    = rise[2];
  assign osc_f    = fall[2];
  assign vco_r    = rise[1];
  assign int_mode = s2_q[0];

  // register file and serial shifter
  logic [31:0] regs_q [REG_NUM];  // registers 26 to 31
  logic [31:0] sh_q;              // incoming word
  logic [4:0]  waddr;             // address of latched word
  logic        wr30;              // feedback register written
  logic        rb_lvl;            // readback latch level

  assign waddr  = sh_q[ADDR_W-1:0];
  assign wr30   = le_r && (waddr == A_L2_FB);
  assign rb_lvl = regs_q[5][RB_LE_BIT];

  // shift data in msb first while latch enable is low
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sh_q <= '0;
    end else if (sclk_r && !le) begin
      sh_q <= {sh_q[30:0], sdat};
    end
  end

  // latch enable rise commits the word; foreign addresses are ignored
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < REG_NUM; i++) begin
        regs_q[i] <= REG_RST;
      end
    end else if (le_r && (waddr >= 5'(REG_FIRST))) begin
      regs_q[3'(waddr - 5'(REG_FIRST))] <= sh_q;
    end
  end

  // readback path
  logic [31:0] rb_q;    // outgoing word
  logic        rb_on;   // pin sits at readback level
  logic        rb_on_q; // previous readback state
  logic [4:0]  rb_addr; // selected register
  logic [31:0] rb_sel;  // selected word, zero if not held here

  assign rb_on   = (le == rb_lvl);
  assign rb_addr = regs_q[5][RB_ADDR_LSB +: 5];
  assign rb_sel  = (rb_addr >= 5'(REG_FIRST)) ?
                   regs_q[3'(rb_addr - 5'(REG_FIRST))] : '0;

  // load on entering the level, then shift on serial clock fall
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rb_q    <= '0;
      rb_on_q <= 1'b0;
    end else begin
      rb_on_q <= rb_on;
      if (rb_on && !rb_on_q) begin
        rb_q <= rb_sel;
      end else if (rb_on && sclk_f) begin
        rb_q <= {rb_q[30:0], 1'b0};
      end
    end
  end
  assign SER_DOUT    = rb_q[31];
  assign SER_DOUT_OE = rb_on_q;

  // field views
  logic [1:0]      pre_code [3];
  logic [L1_DIV_W-1:0] l1_r;
  logic [L1_DIV_W-1:0] l1_n;
  logic [L2_R_W-1:0]   l2_r;
  logic [N_W-1:0]  l2_n;
  logic [N_W-1:0]  l2_ncal;
  logic [CNT_W-1:0] lk_tgt;
  logic [2:0]      p_code;

  assign l1_r    = regs_q[1][L1_R_LSB +: L1_DIV_W];
  assign l1_n    = regs_q[2][L1_N_LSB +: L1_DIV_W];
  assign l2_r    = regs_q[2][L2_R_LSB +: L2_R_W];
  assign l2_n    = regs_q[4][N_LSB +: N_W];
  assign l2_ncal = regs_q[3][NCAL_LSB +: N_W];
  assign p_code  = regs_q[4][P_LSB +: 3];
  // zero count is reserved and run as one
  assign lk_tgt  = (regs_q[0][CNT_LSB +: CNT_W] == '0) ?
                   CNT_W'(1) : regs_q[0][CNT_LSB +: CNT_W];

  // loop1 reference: a pre-divider per input, then selection
  logic [2:0] pre_tick;  // per input divided edges
  logic       l1_pre;    // selected pre-divided edge
  logic       l1_rt;     // loop1 reference tick
  logic       l1_ft;     // loop1 feedback tick
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pre
      assign pre_code[gi] = regs_q[1][PRE_LSB + PRE_W * gi +: PRE_W];
      dpl_div #(.W(4)) u_pre (
        .clk     (MCLK),
        .rst     (RST),
        .en      (ref_r[gi]),
        .div     (4'h1 << pre_code[gi]),
        .restart (1'b0),
        .tick    (pre_tick[gi])
      );
    end
  endgenerate

  // each input keeps its own ratio, so the R input rate holds on a switch
  assign l1_pre = (act < 2'h3) ? pre_tick[act] : 1'b0;

  dpl_div #(.W(L1_DIV_W)) u_l1r (
    .clk     (MCLK),
    .rst     (RST),
    .en      (l1_pre),
    .div     (l1_r),
    .restart (1'b0),
    .tick    (l1_rt)
  );
  dpl_div #(.W(L1_DIV_W)) u_l1n (
    .clk     (MCLK),
    .rst     (RST),
    .en      (l1fb_r),
    .div     (l1_n),
    .restart (1'b0),
    .tick    (l1_ft)
  );

  // loop2 reference and feedback chain
  logic           l2_in;   // reference edge into R divider
  logic           l2_rt;   // loop2 reference tick
  logic           p_tick;  // prescaler output
  logic           l2_ft;   // loop2 feedback tick
  logic [3:0]     p_div;   // prescale ratio
  logic [N_W-1:0] n_sel;   // feedback ratio in use
  dpl_cal_e       cal_q;   // calibration state

  // doubling uses both edges of the oscillator input
  assign l2_in = regs_q[0][DBL_BIT] ? (osc_r | osc_f) : osc_r;
  // code zero is eight, one and two are two, others are themselves
  assign p_div = (p_code == 3'h0) ? 4'h8 :
                 (p_code < 3'h3) ? 4'h2 : {1'b0, p_code};
  assign n_sel = (cal_q == CAL_RUN) ? l2_ncal : l2_n;

  dpl_div #(.W(L2_R_W)) u_l2r (
    .clk     (MCLK),
    .rst     (RST),
    .en      (l2_in),
    .div     (l2_r),
    .restart (1'b0),
    .tick    (l2_rt)
  );
  dpl_div #(.W(4)) u_l2p (
    .clk     (MCLK),
    .rst     (RST),
    .en      (vco_r),
    .div     (p_div),
    .restart (1'b0),
    .tick    (p_tick)
  );
  // restarted at calibration start so the new ratio acts at once
  dpl_div #(.W(N_W)) u_l2n (
    .clk     (MCLK),
    .rst     (RST),
    .en      (p_tick),
    .div     (n_sel),
    .restart (wr30 && int_mode),
    .tick    (l2_ft)
  );

  // phase detectors: pulse from reference tick until feedback tick; feedback first gives no pulse
  logic l1_up_q, l1_dn_q, l2_up_q, l2_dn_q;
  logic l1_pos, l2_pos, l1_hiz, l2_hiz;
  assign l1_pos = regs_q[1][L1_POL_BIT];
  assign l2_pos = regs_q[0][L2_POL_BIT];
  assign l1_hiz = regs_q[1][L1_HIZ_BIT];
  assign l2_hiz = regs_q[0][L2_HIZ_BIT];

  // loop1 detector; negative slope swaps the pulses
  always_ff @(posedge MCLK) begin
    if (RST || (l1_rt && l1_ft)) begin
      l1_up_q <= 1'b0;
      l1_dn_q <= 1'b0;
    end else if (l1_rt) begin
      l1_up_q <= l1_pos;
      l1_dn_q <= !l1_pos;
    end else if (l1_ft) begin
      l1_up_q <= 1'b0;
      l1_dn_q <= 1'b0;
    end
  end

  // loop2 detector, same scheme
  always_ff @(posedge MCLK) begin
    if (RST || (l2_rt && l2_ft)) begin
      l2_up_q <= 1'b0;
      l2_dn_q <= 1'b0;
    end else if (l2_rt) begin
      l2_up_q <= l2_pos;
      l2_dn_q <= !l2_pos;
    end else if (l2_ft) begin
      l2_up_q <= 1'b0;
      l2_dn_q <= 1'b0;
    end
  end

  // pump drives; tri-state wins over any pulse, current codes pass unchanged
  always_ff @(posedge MCLK) begin
    if (RST) begin
      LOOP1_PUMP         <= '0;
      LOOP2_PUMP         <= '0;
      LOOP1_PUMP_CURRENT <= '0;
      LOOP2_PUMP_CURRENT <= '0;
    end else begin
      LOOP1_PUMP <= '{up: l1_up_q && !l1_hiz, dn: l1_dn_q && !l1_hiz,
                      oe: !l1_hiz};
      LOOP2_PUMP <= '{up: l2_up_q && !l2_hiz, dn: l2_dn_q && !l2_hiz,
                      oe: !l2_hiz};
      LOOP1_PUMP_CURRENT <= regs_q[1][L1_CUR_LSB +: 2];
      LOOP2_PUMP_CURRENT <= regs_q[0][L2_CUR_LSB +: 2];
    end
  end

  // loop2 phase error measure: cycles from first edge to the other
  logic       pe_pend_q;  // one edge seen, waiting
  logic       pe_rside_q; // waiting edge was reference
  logic [3:0] pe_cnt_q;   // cycles waited
  logic       hit;        // detector cycle inside window
  logic       miss;       // detector cycle outside window

  always_comb begin
    hit  = 1'b0;
    miss = 1'b0;
    if (l2_rt && l2_ft) begin
      hit = 1'b1;
    end else if (pe_pend_q) begin
      if ((l2_rt && !pe_rside_q) || (l2_ft && pe_rside_q)) begin
        hit = (pe_cnt_q < 4'(WIN_CYC));
        miss = !hit;
      end else if (l2_rt || l2_ft || (pe_cnt_q >= 4'(WIN_CYC))) begin
        miss = 1'b1;  // same side twice or window passed
      end
    end
  end

  // pending tracker
  always_ff @(posedge MCLK) begin
    if (RST || hit || miss || (l2_rt && l2_ft)) begin
      pe_pend_q  <= 1'b0;
      pe_rside_q <= 1'b0;
      pe_cnt_q   <= '0;
    end else if (!pe_pend_q && (l2_rt || l2_ft)) begin
      pe_pend_q  <= 1'b1;
      pe_rside_q <= l2_rt;
      pe_cnt_q   <= '0;
    end else if (pe_pend_q) begin
      pe_cnt_q <= pe_cnt_q + 4'h1;
    end
  end

  // lock counter; a fresh calibration starts from zero as well
  logic [CNT_W-1:0] lk_cnt_q;
  logic             locked_q;
  always_ff @(posedge MCLK) begin
    if (RST || miss || (wr30 && int_mode)) begin
      lk_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (hit && (lk_cnt_q < lk_tgt)) begin
      lk_cnt_q <= lk_cnt_q + CNT_W'(1);
      locked_q <= (lk_cnt_q + CNT_W'(1) >= lk_tgt);
    end
  end

  // calibration sequencer; it ends on lock or on timeout
  logic [TW-1:0] cal_cnt_q;
  logic          sync_q;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cal_q     <= CAL_IDLE;
      cal_cnt_q <= '0;
      sync_q    <= 1'b0;
    end else begin
      sync_q <= 1'b0;
      if (wr30 && int_mode) begin
        cal_q     <= CAL_RUN;
        cal_cnt_q <= '0;
        sync_q    <= 1'b1;
      end else begin
        case (cal_q)
          CAL_RUN: begin
            cal_cnt_q <= cal_cnt_q + TW'(1);
            if (locked_q || (cal_cnt_q >= TW'(CAL_TIMEOUT_CYC - 1))) begin
              cal_q <= CAL_DONE;
            end
          end
          CAL_DONE: cal_q <= CAL_IDLE;
          default:  cal_q <= CAL_IDLE;
        endcase
      end
    end
  end

  // status outputs
  assign LOOP2_LOCKED    = locked_q;
  assign CAL_ACTIVE      = (cal_q == CAL_RUN);
  assign SYNC_PULSE      = sync_q;
  assign LOOP2_FAST_PD   = regs_q[3][FAST_PD_BIT];
  assign OSC_INPUT_RANGE = regs_q[3][OSC_RNG_LSB +: 3];

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_cal_req;
    wr30 && int_mode;
  endsequence
  a_lock_count_met: assert property (locked_q |-> lk_cnt_q >= lk_tgt)
    else $error("lock shown before count reached");
  a_loop2_hiz_pin: assert property (l2_hiz |=> !LOOP2_PUMP.oe && !LOOP2_PUMP.up)
    else $error("loop2 pump driven while tri-stated");
  a_loop1_pol_dir: assert property (l1_rt && !l1_ft && !l1_pos |=> l1_dn_q && !l1_up_q)
    else $error("loop1 polarity not applied");
  a_loop1_hiz_pin: assert property (l1_hiz |=> !LOOP1_PUMP.oe && !LOOP1_PUMP.dn)
    else $error("loop1 pump driven while tri-stated");
  a_cal_div_used: assert property (cal_q == CAL_RUN |-> n_sel == l2_ncal)
    else $error("calibration divider not in use");
  a_cal_start_run: assert property (s_cal_req |=> cal_q == CAL_RUN ##0 CAL_ACTIVE)
    else $error("calibration did not start");
  a_cal_sync_out: assert property (s_cal_req |=> SYNC_PULSE ##1 !SYNC_PULSE)
    else $error("sync pulse missing at calibration start");
  a_miss_clear_lock: assert property (miss |=> !locked_q && lk_cnt_q == '0)
    else $error("miss did not clear lock");
  a_normal_div_back: assert property (cal_q != CAL_RUN |-> n_sel == l2_n)
    else $error("normal divider not restored");
  a_rb_level_oe: assert property ((le == rb_lvl) [*2] |-> SER_DOUT_OE)
    else $error("readback output not enabled at level");
endmodule // dpl_top

//--- src/dpl_pkg.sv
// shared constants and types of the dual loop divider and lock block
package dpl_pkg;
  // serial word layout
  localparam int WORD_W     = 32;
  localparam int ADDR_W     = 5;
  localparam int REG_FIRST  = 26;
  localparam int REG_NUM    = 6;
  // register indices carried in the serial address field
  localparam logic [4:0] A_L2_CFG  = 5'h1a;
  localparam logic [4:0] A_L1_CFG  = 5'h1b;
  localparam logic [4:0] A_DIV_CFG = 5'h1c;
  localparam logic [4:0] A_OSC_CFG = 5'h1d;
  localparam logic [4:0] A_L2_FB   = 5'h1e;
  localparam logic [4:0] A_RB_CTL  = 5'h1f;
  localparam logic [31:0] REG_RST  = 32'h0;
  // loop2 lock, pump and reference doubler register fields
  localparam int WIN_LSB    = 30;
  localparam int DBL_BIT    = 29;
  localparam int L2_POL_BIT = 28;
  localparam int L2_CUR_LSB = 26;
  localparam int CNT_LSB    = 6;
  localparam int CNT_W      = 14;
  localparam int L2_HIZ_BIT = 5;
  // loop1 pump and reference fields
  localparam int L1_POL_BIT = 28;
  localparam int L1_CUR_LSB = 26;
  localparam int PRE_LSB    = 20;
  localparam int PRE_W      = 2;
  localparam int L1_R_LSB   = 6;
  localparam int L1_HIZ_BIT = 5;
  // divider register fields
  localparam int L2_R_LSB   = 20;
  localparam int L2_R_W     = 12;
  localparam int L1_N_LSB   = 6;
  localparam int L1_DIV_W   = 14;
  // oscillator range, fast detector, calibration divider
  localparam int OSC_RNG_LSB = 24;
  localparam int FAST_PD_BIT = 23;
  localparam int NCAL_LSB    = 5;
  // loop2 feedback fields
  localparam int P_LSB      = 24;
  localparam int N_LSB      = 5;
  localparam int N_W        = 18;
  // readback control fields
  localparam int RB_LE_BIT   = 21;
  localparam int RB_ADDR_LSB = 16;
  // timing
  localparam int CLK_PS       = 5000;
  localparam int LOCK_WIN_PS  = 3700;
  localparam int WIN_CYC      = (LOCK_WIN_PS / CLK_PS) > 0 ? LOCK_WIN_PS / CLK_PS : 1;
  localparam int CAL_TIMEOUT  = 100000;
  // calibration sequencer states, gray from idle through run to done
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b11
  } dpl_cal_e;
  // one charge pump drive: pulses plus output enable
  typedef struct packed {
    logic up;
    logic dn;
    logic oe;
  } dpl_pump_s;
endpackage

//--- src/dpl_div.sv
// programmable pulse divider: one tick per div input pulses
`timescale 1ns/100ps
module dpl_div
  import dpl_pkg::*;
#(
  parameter int W = 14
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // input pulses and divide value
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  input  wire logic         restart,
  // output tick
  output logic              tick
);
  logic [W-1:0] cnt_q;   // pulses seen in this period
  logic [W-1:0] last;    // terminal count
  logic         tick_q;  // registered tick

  // zero is reserved; it is run as divide by one
  assign last = (div == '0) ? '0 : div - W'(1);

  // count pulses, wrap on terminal count
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (en) begin
        if (cnt_q >= last) begin
          cnt_q  <= '0;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
      end
    end
  end

  assign tick = tick_q;
endmodule // dpl_div

//--- tb/dpl_host_model.sv
// host-side model of the serial configuration pins: writes and reads back words
`timescale 1ns/100ps
module dpl_host_model (
  // device clock, used only to pace the pins
  input  wire logic clk,
  // serial pins toward the device
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_le,
  // readback pins from the device
  input  wire logic ser_dout,
  input  wire logic ser_dout_oe
);
  localparam int HOLD = 4; // cycles per pin level; device needs 3 to sample

  // serial clock stands low and latch stays high outside frames
  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_le   = 1'b1;
  end

  // wait whole device clocks; returns on a rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one word, msb first, committed by the latch-enable rise
  task automatic write_word(input logic [31:0] w);
    idle(1);
    ser_le <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      idle(HOLD);
      ser_data <= w[i];
      idle(HOLD);
      ser_clk <= 1'b1;
      idle(HOLD);
      ser_clk <= 1'b0;
    end
    idle(HOLD);
    ser_le <= 1'b1;
    idle(HOLD);
    ser_data <= ~w[0]; // no stale bit left on the data line
  endtask

  // readback with level bit 0: latch held low while bits come out
  task automatic read_word(output logic [31:0] r, output logic oe);
    idle(1);
    ser_data <= 1'b0; // zeros shift in as address 0, which the device drops
    ser_le <= 1'b0;
    idle(2 * HOLD);
    oe = ser_dout_oe;
    r[31] = ser_dout;
    for (int i = 30; i >= 0; i--) begin
      idle(HOLD);
      ser_clk <= 1'b1;
      idle(HOLD);
      ser_clk <= 1'b0;
      idle(2 * HOLD); // next bit after the fall plus pin latency
      r[i] = ser_dout;
    end
    idle(HOLD);
    ser_le <= 1'b1;
    idle(HOLD);
  endtask
endmodule // dpl_host_model

//--- tb/tb.sv
// self-checking bench for the dual loop divider and lock block
`timescale 1ns/100ps
module tb;
  import dpl_pkg::*;
  localparam int CAL_CYC = 200;   // shortened calibration timeout
  localparam int LIMIT   = 40000; // cycle ceiling for the whole run
  typedef struct packed {
    logic [31:0] word; // serial word sent
    logic [9:0]  obs;  // pump, detector and range outputs expected after it
  } dpl_row_s;
  // clock, reset and pins
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ser_clk, ser_data, ser_le, ser_dout, ser_dout_oe;
  logic [2:0]  ref_in = 3'h0;
  logic        osc_int_mode = 1'b0;
  logic        ref_run = 1'b0;
  logic [1:0]  act_in = 2'h0;    // active reference input select
  logic        l1_fb = 1'b0;     // loop1 feedback pin
  logic        osc_in = 1'b0;    // loop2 reference pin
  logic        vco_in = 1'b0;    // loop2 oscillator pin
  logic        loop_run = 1'b0;  // loop2 pins toggling
  logic        fb_run = 1'b0;    // oscillator pin follows the reference
  dpl_pump_s   l1_pump, l2_pump;
  logic [1:0]  l1_cur, l2_cur;
  logic        locked, cal_active, sync_pulse, fast_pd;
  logic [2:0]  osc_range;
  int          cycles = 0, syncs = 0, ups = 0, dns = 0, bad_count = 0, checked = 0;
  wire  [9:0]  obs = {l1_cur, l1_pump.oe, l2_cur, l2_pump.oe, fast_pd, osc_range};
  // window code 2, nonzero counts, legal range codes only
  dpl_row_s    rows [11] = '{
    '{32'h0c00001b, 10'h390}, '{32'h0800003b, 10'h210}, '{32'h8400007a, 10'h220},
    '{32'h8c00005a, 10'h270}, '{32'h0480001d, 10'h27c}, '{32'h0200001d, 10'h272},
    '{32'h0180001d, 10'h279}, '{32'h0000001d, 10'h270}, '{32'h0400001b, 10'h1f0},
    '{32'h8800005a, 10'h1d0}, '{32'hffffffe5, 10'h1d0}};

  always #2.5 mclk = ~mclk;

  dpl_host_model dpl_host_model_inst (.clk(mclk), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_le(ser_le), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe));

  dpl_top #(.CAL_TIMEOUT_CYC(CAL_CYC)) dpl_top_inst (
    .MCLK(mclk), .RST(rst), .SER_CLK(ser_clk), .SER_DATA(ser_data), .SER_LE(ser_le),
    .SER_DOUT(ser_dout), .SER_DOUT_OE(ser_dout_oe), .REF_IN(ref_in),
    .ACTIVE_INPUT(act_in), .L1_FB_IN(l1_fb), .OSC_IN(osc_in), .VCO_IN(vco_in),
    .OSC_INTERNAL_MODE(osc_int_mode), .LOOP1_PUMP(l1_pump), .LOOP1_PUMP_CURRENT(l1_cur),
    .LOOP2_PUMP(l2_pump), .LOOP2_PUMP_CURRENT(l2_cur), .LOOP2_LOCKED(locked),
    .CAL_ACTIVE(cal_active), .SYNC_PULSE(sync_pulse), .LOOP2_FAST_PD(fast_pd),
    .OSC_INPUT_RANGE(osc_range));

  // verdict and end of run, reached from the main sequence or the ceiling
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one comparison, four-state exact
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // point readback at a register, then shift it out
  task automatic read_reg(input logic [4:0] a, output logic [31:0] r);
    logic oe;
    dpl_host_model_inst.write_word({10'h0, 1'b0, a, 11'h0, A_RB_CTL});
    dpl_host_model_inst.read_word(r, oe);
    check("readback enable", {31'h0, oe}, 32'h1);
  endtask

  // cycle count, pulse tallies and the hang ceiling
  always @(posedge mclk) begin
    cycles++;
    if (sync_pulse === 1'b1) syncs++;
    if (l1_pump.up === 1'b1) ups++;
    if (l1_pump.dn === 1'b1) dns++;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("run stopped at the cycle ceiling");
      give_verdict();
    end
  end

  // reference input 0 toggles every 8 cycles while enabled
  always @(posedge mclk) begin
    if (ref_run && cycles % 8 == 0) ref_in[0] <= ~ref_in[0];
  end

  // loop2 reference and oscillator pins toggle together; cutting fb_run stops feedback
  always @(posedge mclk) begin
    if (loop_run && cycles % 8 == 4) begin
      osc_in <= ~osc_in;
      if (fb_run) vco_in <= ~vco_in;
    end
  end

  initial begin
    logic [31:0] r;
    int n0, u0, d0, k;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    dpl_host_model_inst.idle(4);
    check("outputs after reset", {22'h0, obs}, 32'h090);
    read_reg(A_L2_FB, r);
    check("reset register", r, REG_RST);
    $display("reset test done");
    // ordinary settings, each read back; unmapped address reads as zero
    foreach (rows[i]) begin
      dpl_host_model_inst.write_word(rows[i].word);
      dpl_host_model_inst.idle(2);
      check("settings outputs", {22'h0, obs}, {22'h0, rows[i].obs});
      read_reg(rows[i].word[4:0], r);
      check("stored word", {r[31:5], 5'h0}, (rows[i].word[4:0] >= 5'h1a) ?
            {rows[i].word[31:5], 5'h0} : 32'h0);
    end
    $display("settings table done");
    // calibration in internal mode: one sync, bounded run, no lock without feedback
    osc_int_mode <= 1'b1;
    n0 = syncs;
    dpl_host_model_inst.write_word(32'h0300009e);
    dpl_host_model_inst.idle(1);
    check("sync count", syncs - n0, 1);
    check("calibration running", {31'h0, cal_active}, 32'h1);
    k = 0;
    while (cal_active === 1'b1 && k < 400) begin
      dpl_host_model_inst.idle(1);
      k++;
    end
    check("calibration ends on timeout", {31'h0, k > 180 && k < 230}, 32'h1);
    check("lock without feedback", {31'h0, locked}, 32'h0);
    // external mode: a write to the same register starts nothing
    osc_int_mode <= 1'b0;
    n0 = syncs;
    dpl_host_model_inst.write_word(32'h0300009e);
    dpl_host_model_inst.idle(1);
    check("sync in external mode", syncs - n0, 0);
    check("calibration in external mode", {31'h0, cal_active}, 32'h0);
    $display("calibration test done");
    // loop1 direction: reference ticks only, polarity picks the pulse line
    dpl_host_model_inst.write_word(32'h0020005c);
    for (int p = 0; p < 2; p++) begin
      dpl_host_model_inst.write_word({3'h0, p[0], 21'h0, 1'b1, 6'h1b});
      ref_run <= 1'b1;
      // the old pulse stands until the first reference tick under the new polarity
      dpl_host_model_inst.idle(40);
      u0 = ups;
      d0 = dns;
      dpl_host_model_inst.idle(160);
      ref_run <= 1'b0;
      check("pump direction", {30'h0, ups > u0, dns > d0}, p ? 32'h2 : 32'h1);
    end
    $display("polarity test done");
    // input switch: a feedback edge clears the pulse, only the selected input counts
    act_in <= 2'h1;
    l1_fb <= 1'b1;
    dpl_host_model_inst.idle(8);
    l1_fb <= 1'b0;
    u0 = ups;
    ref_run <= 1'b1;
    dpl_host_model_inst.idle(100);
    check("deselected input", ups - u0, 0);
    act_in <= 2'h0;
    dpl_host_model_inst.idle(100);
    ref_run <= 1'b0;
    check("selected input", {31'h0, ups > u0}, 32'h1);
    $display("input switch test done");
    // loop2 lock: count of in-window detector cycles, then feedback cut
    dpl_host_model_inst.write_word(32'h8800011a); // window code 2, count 4
    dpl_host_model_inst.write_word(32'h0100003e); // prescale 2, divide 1
    loop_run <= 1'b1;
    fb_run <= 1'b1;
    dpl_host_model_inst.idle(60);
    check("lock before count", {31'h0, locked}, 32'h0);
    dpl_host_model_inst.idle(240);
    check("lock after count", {31'h0, locked}, 32'h1);
    fb_run <= 1'b0;
    dpl_host_model_inst.idle(100);
    loop_run <= 1'b0;
    check("lock after feedback loss", {31'h0, locked}, 32'h0);
    $display("lock test done");
    give_verdict();
  end
endmodule // tb
